// *** rtl/ccr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial clock pin
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Serial data pin
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Results from the sensing core
    input wire logic meas_valid,
    input wire ccr_pkg::ccr_meas_t meas,
    // Status
    output logic [7:0] reg_ptr,
    output logic bus_busy,
    output logic init_captured
);
    import ccr_pkg::*;

    // Reset release
    logic [1:0] rst_sync_q;
    logic [1:0] rst_sync_d;
    logic rst_int_b;

    // Deassert in two steps
    always_comb begin
        rst_sync_d = {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end

    assign rst_int_b = rst_sync_q[1];

    // Pin sampling
    ccr_pins_t pins_async;
    ccr_pins_t pins_s;
    ccr_pins_t pins_dly_q;
    ccr_pins_t pins_dly_d;

    assign pins_async = '{scl: scl_in, sda: sda_in};

    ccr_sync u_sync (
        .clk(clk),
        .rst_int_b(rst_int_b),
        .pins_async(pins_async),
        .pins_sync(pins_s)
    );

    always_comb begin
        pins_dly_d = pins_s;
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            pins_dly_q <= 2'h3;
        end else begin
            pins_dly_q <= pins_dly_d;
        end
    end

    // Bus events
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_comb begin
        scl_rise = pins_s.scl && !pins_dly_q.scl;
        scl_fall = !pins_s.scl && pins_dly_q.scl;
        bus_start = pins_s.scl && pins_dly_q.scl && pins_dly_q.sda && !pins_s.sda;
        bus_stop = pins_s.scl && pins_dly_q.scl && !pins_dly_q.sda && pins_s.sda;
    end

    // Register bank
    logic rd_new;
    logic rd_load;
    logic [7:0] rd_addr;
    logic [7:0] rd_byte;

    ccr_bank u_bank (
        .clk(clk),
        .rst_int_b(rst_int_b),
        .meas_valid(meas_valid),
        .meas(meas),
        .rd_new(rd_new),
        .rd_load(rd_load),
        .rd_addr(rd_addr),
        .rd_byte(rd_byte),
        .init_captured(init_captured)
    );

    // Target state
    ccr_state_t state_q;
    ccr_state_t state_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic first_q;
    logic first_d;
    logic ack_q;
    logic ack_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic busy_q;
    logic busy_d;

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shreg_d = shreg_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        ack_d = ack_q;
        sda_oe_d = sda_oe_q;
        busy_d = busy_q;
        rd_new = 1'b0;
        rd_load = 1'b0;
        rd_addr = (state_q == ccr_st_rack) ? ptr_q + 8'h01 : ptr_q;
        case (state_q)
            ccr_st_idle: begin
                sda_oe_d = 1'b0;
                bit_cnt_d = 4'h0;
                first_d = 1'b0;
            end
            ccr_st_addr: begin
                if (scl_rise) begin
                    shreg_d = {shreg_q[6:0], pins_s.sda};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                end else if (scl_fall && bit_cnt_q == `CCR_BITS_PER_BYTE) begin
                    bit_cnt_d = 4'h0;
                    if (shreg_q == `CCR_DEV_WR_ADDR || shreg_q == `CCR_DEV_RD_ADDR) begin
                        rw_d = shreg_q[0]; // [RULE12]
                        sda_oe_d = 1'b1; // [RULE12]
                        state_d = ccr_st_addr_ack;
                    end else begin
                        busy_d = 1'b0;
                        state_d = ccr_st_idle;
                    end
                end
            end
            ccr_st_addr_ack: begin
                if (scl_fall) begin
                    bit_cnt_d = 4'h0;
                    if (rw_q) begin
                        rd_load = 1'b1; // [RULE14] [RULE15]
                        tx_d = rd_byte;
                        sda_oe_d = !rd_byte[7];
                        state_d = ccr_st_rdata;
                    end else begin
                        sda_oe_d = 1'b0;
                        first_d = 1'b1;
                        state_d = ccr_st_wdata;
                    end
                end
            end
            ccr_st_wdata: begin
                if (scl_rise) begin
                    shreg_d = {shreg_q[6:0], pins_s.sda};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                end else if (scl_fall && bit_cnt_q == `CCR_BITS_PER_BYTE) begin
                    if (first_q) begin
                        ptr_d = shreg_q; // [RULE13]
                    end
                    sda_oe_d = 1'b1; // [RULE16]
                    state_d = ccr_st_wack;
                end
            end
            ccr_st_wack: begin
                if (scl_fall) begin
                    sda_oe_d = 1'b0;
                    first_d = 1'b0; // [RULE16]
                    bit_cnt_d = 4'h0;
                    state_d = ccr_st_wdata;
                end
            end
            ccr_st_rdata: begin
                if (scl_rise) begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                end else if (scl_fall) begin
                    if (bit_cnt_q == `CCR_BITS_PER_BYTE) begin
                        sda_oe_d = 1'b0;
                        ack_d = 1'b0;
                        state_d = ccr_st_rack;
                    end else begin
                        tx_d = {tx_q[6:0], 1'b0};
                        sda_oe_d = !tx_q[6];
                    end
                end
            end
            ccr_st_rack: begin
                if (scl_rise) begin
                    ack_d = !pins_s.sda;
                end else if (scl_fall) begin
                    bit_cnt_d = 4'h0;
                    if (ack_q) begin
                        ptr_d = ptr_q + 8'h01; // [RULE14]
                        rd_load = 1'b1; // [RULE15]
                        tx_d = rd_byte;
                        sda_oe_d = !rd_byte[7];
                        state_d = ccr_st_rdata;
                    end else begin
                        state_d = ccr_st_idle; // [RULE14]
                    end
                end
            end
            default: begin
                state_d = ccr_st_idle;
                sda_oe_d = 1'b0;
            end
        endcase
        // Start or repeated start wins over any state
        if (bus_start) begin
            rd_new = 1'b1;
            rd_load = 1'b0;
            state_d = ccr_st_addr;
            bit_cnt_d = 4'h0;
            sda_oe_d = 1'b0;
            busy_d = 1'b1;
        end else if (bus_stop) begin
            state_d = ccr_st_idle;
            sda_oe_d = 1'b0;
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            state_q <= ccr_st_idle;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= `CCR_REG_HEADING_HI;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shreg_q <= shreg_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            ack_q <= ack_d;
            sda_oe_q <= sda_oe_d;
            busy_q <= busy_d;
        end
    end

    // Open-drain drive levels, clock never stretched
    logic drive_low_q;
    logic drive_low_d;
    logic scl_oe_q;
    logic scl_oe_d;

    // Pins only ever pull low
    always_comb begin
        drive_low_d = 1'b0;
        scl_oe_d = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            drive_low_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            drive_low_q <= drive_low_d;
            scl_oe_q <= scl_oe_d;
        end
    end

    assign sda_out = drive_low_q;
    assign scl_out = drive_low_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign reg_ptr = ptr_q;
    assign bus_busy = busy_q;
endmodule
`default_nettype wire

// *** include/ccr_defines.svh ***
// What this block does
// RULE1 - Results are 16-bit pairs: upper byte at even number, lower at next odd.
// RULE2 - Heading pair holds unsigned count of tenths of a degree.
// RULE3 - All other pairs hold signed two's complement 16-bit values.
// RULE4 - Heading upper byte at register 0x00, lower byte at 0x01.
// RULE5 - Dip angle pair at 0x02 upper, 0x03 lower.
// RULE6 - Field strength pair at 0x04 upper, 0x05 lower.
// RULE7 - Power-up bearing pair at 0x06 upper, 0x07 lower.
// RULE8 - Bearing at power-up is captured once and kept readable afterwards.
// RULE9 - Nose tilt pair at 0x08 upper, 0x09 lower.
// RULE10 - Bank angle pair at 0x0A upper, 0x0B lower.
// RULE11 - Turn angle pair at 0x0C upper, 0x0D lower.
// RULE12 - Target answers write address byte 0x88 and read address byte 0x89.
// RULE13 - First data byte of a write transfer loads the register pointer.
// RULE14 - Read returns byte at pointer; pointer steps on each host acknowledge.
// RULE15 - Single reads and block reads from any register number work.
// RULE16 - Registers are read-only; extra written bytes are ignored.
// RULE17 - Both bytes of a pair update together; no torn pair in a burst.
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

`define CCR_DEV_WR_ADDR 8'h88
`define CCR_DEV_RD_ADDR 8'h89
`define CCR_REG_HEADING_HI 8'h00
`define CCR_REG_HEADING_LO 8'h01
`define CCR_REG_DIP_HI 8'h02
`define CCR_REG_DIP_LO 8'h03
`define CCR_REG_FIELD_HI 8'h04
`define CCR_REG_FIELD_LO 8'h05
`define CCR_REG_BEARING_HI 8'h06
`define CCR_REG_BEARING_LO 8'h07
`define CCR_REG_TILT_HI 8'h08
`define CCR_REG_TILT_LO 8'h09
`define CCR_REG_BANK_HI 8'h0a
`define CCR_REG_BANK_LO 8'h0b
`define CCR_REG_TURN_HI 8'h0c
`define CCR_REG_TURN_LO 8'h0d
`define CCR_PAIR_COUNT 7
`define CCR_PAIR_HEADING 3'h0
`define CCR_PAIR_BEARING 3'h3
`define CCR_BITS_PER_BYTE 4'h8
`define CCR_WORD_RESET 16'h0000
`define CCR_BYTE_RESET 8'h00

`endif

// *** include/ccr_pkg.sv ***
package ccr_pkg;

    typedef logic [15:0] ccr_word_t;

    typedef enum logic [2:0] {
        ccr_st_idle,
        ccr_st_addr,
        ccr_st_addr_ack,
        ccr_st_wdata,
        ccr_st_wack,
        ccr_st_rdata,
        ccr_st_rack
    } ccr_state_t;

    // Fresh results from the sensing core
    typedef struct packed {
        ccr_word_t heading;
        ccr_word_t dip_angle;
        ccr_word_t field_strength;
        ccr_word_t nose_tilt;
        ccr_word_t bank_angle;
        ccr_word_t turn_angle;
    } ccr_meas_t;

    // Synchronised bus pin levels
    typedef struct packed {
        logic scl;
        logic sda;
    } ccr_pins_t;

endpackage

// *** rtl/ccr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_int_b,
    // Pins
    input wire ccr_pkg::ccr_pins_t pins_async,
    output ccr_pkg::ccr_pins_t pins_sync
);
    import ccr_pkg::*;

    ccr_pins_t meta_q;
    ccr_pins_t meta_d;
    ccr_pins_t sync_q;
    ccr_pins_t sync_d;

    // Idle bus level is high
    always_comb begin
        meta_d = pins_async;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pins_sync = sync_q;
endmodule
`default_nettype wire

// *** rtl/ccr_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_int_b,
    // Result updates
    input wire logic meas_valid,
    input wire ccr_pkg::ccr_meas_t meas,
    // Read port
    input wire logic rd_new,
    input wire logic rd_load,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_byte,
    output logic init_captured
);
    import ccr_pkg::*;

    ccr_word_t words_q [`CCR_PAIR_COUNT];
    ccr_word_t words_d [`CCR_PAIR_COUNT];
    ccr_word_t meas_words [`CCR_PAIR_COUNT];
    logic init_q;
    logic init_d;
    logic [7:0] shadow_q;
    logic [7:0] shadow_d;
    logic [2:0] shadow_idx_q;
    logic [2:0] shadow_idx_d;
    logic shadow_vld_q;
    logic shadow_vld_d;
    logic [2:0] idx;
    logic in_range;
    logic use_shadow;

    // Pair order in the map
    always_comb begin
        meas_words[0] = meas.heading; // [RULE4] [RULE2]
        meas_words[1] = meas.dip_angle; // [RULE5] [RULE3]
        meas_words[2] = meas.field_strength; // [RULE6]
        meas_words[3] = meas.heading; // [RULE7]
        meas_words[4] = meas.nose_tilt; // [RULE9]
        meas_words[5] = meas.bank_angle; // [RULE10]
        meas_words[6] = meas.turn_angle; // [RULE11]
    end

    // Whole words load in one cycle
    for (genvar i = 0; i < `CCR_PAIR_COUNT; i++) begin : g_pair
        always_comb begin
            words_d[i] = words_q[i];
            if (meas_valid) begin
                if (3'(i) != `CCR_PAIR_BEARING || !init_q) begin
                    words_d[i] = meas_words[i]; // [RULE17] [RULE8]
                end
            end
        end
        always_ff @(posedge clk or negedge rst_int_b) begin
            if (!rst_int_b) begin
                words_q[i] <= `CCR_WORD_RESET;
            end else begin
                words_q[i] <= words_d[i];
            end
        end
    end

    always_comb begin
        idx = rd_addr[3:1];
        in_range = rd_addr <= `CCR_REG_TURN_LO;
        use_shadow = rd_addr[0] && shadow_vld_q && shadow_idx_q == idx;
        init_d = init_q | meas_valid; // [RULE8]
        shadow_d = shadow_q;
        shadow_idx_d = shadow_idx_q;
        shadow_vld_d = shadow_vld_q;
        rd_byte = `CCR_BYTE_RESET;
        if (in_range) begin
            if (!rd_addr[0]) begin
                rd_byte = words_q[idx][15:8]; // [RULE1]
            end else if (use_shadow) begin
                rd_byte = shadow_q; // [RULE17]
            end else begin
                rd_byte = words_q[idx][7:0]; // [RULE1]
            end
        end
        if (rd_new) begin
            shadow_vld_d = 1'b0;
        end else if (rd_load) begin
            shadow_vld_d = 1'b0;
            if (in_range && !rd_addr[0]) begin
                shadow_d = words_q[idx][7:0]; // [RULE17]
                shadow_idx_d = idx;
                shadow_vld_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            init_q <= 1'b0;
            shadow_q <= `CCR_BYTE_RESET;
            shadow_idx_q <= 3'h0;
            shadow_vld_q <= 1'b0;
        end else begin
            init_q <= init_d;
            shadow_q <= shadow_d;
            shadow_idx_q <= shadow_idx_d;
            shadow_vld_q <= shadow_vld_d;
        end
    end

    assign init_captured = init_q;
endmodule
`default_nettype wire

// *** verif/ccr_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus pins
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Results and status
    input wire logic meas_valid,
    input wire ccr_pkg::ccr_meas_t meas,
    input wire logic [7:0] reg_ptr,
    input wire logic bus_busy,
    input wire logic init_captured
);
    import ccr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_scl_not_held: assert property (!scl_oe)
        else $error("clock line driven");
    a_sda_pulls_low: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_init_sticky: assert property (init_captured |=> init_captured)
        else $error("capture flag dropped");
    a_init_cause: assert property ($rose(init_captured) |-> $past(meas_valid))
        else $error("capture flag without update");
    a_ptr_in_frame: assert property ($changed(reg_ptr) |-> bus_busy || $past(bus_busy))
        else $error("pointer moved outside a transfer");
    a_idle_released: assert property (!bus_busy |-> !sda_oe)
        else $error("data driven while idle");
    a_oe_clock_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
        else $error("data changed while clock high");
    a_busy_on_start: assert property ($rose(bus_busy) |->
        !$past(sda_in, 3) && $past(scl_in, 3))
        else $error("busy without start");
endmodule
bind ccr_top ccr_top_chk u_chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .meas_valid(meas_valid), .meas(meas), .reg_ptr(reg_ptr),
    .bus_busy(bus_busy), .init_captured(init_captured));
`default_nettype wire

// *** verif/ccr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
    // Bus wires
    input wire logic sda_wire,
    output logic scl_rel,
    output logic sda_rel
);
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // Start: data falls while clock high
    task automatic start();
        #13 sda_rel = 1'b1;
        scl_rel = 1'b1;
        #80 sda_rel = 1'b0;
        #120 scl_rel = 1'b0;
        #80;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        #80 scl_rel = 1'b1;
        #80 sda_rel = 1'b1;
        #160;
    endtask
    task automatic clock_bit(output logic b);
        #80 scl_rel = 1'b1;
        #120 b = sda_wire;
        #40 scl_rel = 1'b0;
        #80;
    endtask
    // Any byte (address, pointer or data), then target acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_rel = d[i];
            clock_bit(s);
        end
        sda_rel = 1'b1;
        clock_bit(s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_rel = 1'b1;
            clock_bit(d[i]);
        end
        sda_rel = ~ack_it; // No acknowledge on last byte
        clock_bit(s);
    endtask
endmodule
`default_nettype wire

// *** verif/compass_result_registers_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module compass_result_registers_bench;
    import ccr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic meas_valid = 1'b0;
    ccr_meas_t meas = '0;
    logic scl_out, scl_oe, sda_out, sda_oe, bus_busy, init_captured, ack;
    logic [7:0] reg_ptr;
    logic [7:0] rd [0:15];
    wire scl_rel, sda_rel;
    wire scl_w = scl_rel & ~(scl_oe & ~scl_out);
    wire sda_w = sda_rel & ~(sda_oe & ~sda_out);
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    ccr_meas_t m1, m2;

    ccr_top u_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .meas_valid(meas_valid), .meas(meas), .reg_ptr(reg_ptr),
        .bus_busy(bus_busy), .init_captured(init_captured));
    ccr_host u_host (.sda_wire(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));

    always #20 clk = ~clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            complete_run;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input ccr_meas_t m, input logic [15:0] b, input int r);
        logic [15:0] w [0:6];
        w = '{m.heading, m.dip_angle, m.field_strength, b, m.nose_tilt, m.bank_angle,
            m.turn_angle};
        if (r > 13)
            return 8'h00;
        return r[0] ? w[r/2][7:0] : w[r/2][15:8];
    endfunction

    task automatic load(input ccr_meas_t m);
        @(posedge clk);
        meas <= m;
        meas_valid <= 1'b1;
        @(posedge clk);
        meas_valid <= 1'b0;
        #13;
    endtask

    task automatic set_ptr(input logic [7:0] p);
        u_host.start();
        u_host.wr_byte(8'h88, ack);
        check(ack, 1'b1, "write address ack");
        u_host.wr_byte(p, ack);
        check(ack, 1'b1, "pointer ack");
        u_host.stop();
    endtask

    task automatic read_n(input int n);
        u_host.start();
        u_host.wr_byte(8'h89, ack);
        check(ack, 1'b1, "read address ack");
        for (int i = 0; i < n; i++)
            u_host.rd_byte(i < n - 1, rd[i]);
        u_host.stop();
    endtask

    task automatic t_reset_state;
        check(reg_ptr, 8'h00, "pointer after reset");
        check(init_captured, 1'b0, "capture flag after reset");
        read_n(2);
        check({rd[0], rd[1]}, 16'h0000, "heading after reset");
        $display("test reset_state done");
    endtask

    task automatic t_block_read;
        load(m1);
        set_ptr(8'h00);
        read_n(15);
        for (int r = 0; r < 15; r++)
            check(rd[r], exp_byte(m1, m1.heading, r), "block byte");
        check(reg_ptr, 8'h0e, "pointer after burst");
        $display("test block_read done");
    endtask

    task automatic t_bearing;
        load(m2);
        set_ptr(8'h06);
        read_n(2);
        check({rd[0], rd[1]}, m1.heading, "bearing kept");
        set_ptr(8'h01);
        read_n(1);
        check(rd[0], m2.heading[7:0], "single read");
        check(init_captured, 1'b1, "capture flag");
        $display("test bearing done");
    endtask

    task automatic t_write_ignored;
        u_host.start();
        u_host.wr_byte(8'h88, ack);
        u_host.wr_byte(8'h03, ack);
        u_host.wr_byte(8'hff, ack);
        check(ack, 1'b1, "extra byte ack");
        u_host.wr_byte(8'haa, ack);
        u_host.stop();
        check(reg_ptr, 8'h03, "pointer after extra bytes");
        read_n(1);
        check(rd[0], m2.dip_angle[7:0], "value unchanged");
        $display("test write_ignored done");
    endtask

    task automatic t_wrong_addr;
        u_host.start();
        u_host.wr_byte(8'h8a, ack);
        check(ack, 1'b0, "foreign address refused");
        u_host.stop();
        check(reg_ptr, 8'h03, "pointer untouched");
        check(bus_busy, 1'b0, "idle after stop");
        $display("test wrong_addr done");
    endtask

    task automatic t_no_tear;
        set_ptr(8'h00);
        u_host.start();
        u_host.wr_byte(8'h89, ack);
        load(m1);
        u_host.rd_byte(1'b1, rd[0]);
        u_host.rd_byte(1'b0, rd[1]);
        u_host.stop();
        check({rd[0], rd[1]}, m2.heading, "pair from one update");
        $display("test no_tear done");
    endtask

    initial begin
        m1 = '{16'h055f, 16'hff38, 16'h0123, 16'h7fff, 16'h8000, 16'hfed4};
        m2 = '{16'h0e0f, 16'h0001, 16'h8001, 16'hc350, 16'h3c3c, 16'ha5a5};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset_state;
        t_block_read;
        t_bearing;
        t_write_ignored;
        t_wrong_addr;
        t_no_tear;
        complete_run;
    end
endmodule
`default_nettype wire
